// ### rtl/mdma_params.svh
// constants for the maintenance-due and mock alarm block
`ifndef MDMA_PARAMS_SVH
`define MDMA_PARAMS_SVH
// register byte offsets
`define MDMA_ADR_CTRL 8'h00
`define MDMA_ADR_RUNSET 8'h04
`define MDMA_ADR_STSET 8'h08
`define MDMA_ADR_RUNCNT 8'h0C
`define MDMA_ADR_STCNT 8'h10
`define MDMA_ADR_STAT 8'h14
`define MDMA_ADR_HIST 8'h18
// control register fields
`define MDMA_CTL_DOSEL_LSB 0
`define MDMA_CTL_DISEL_LSB 8
`define MDMA_CTL_CONFIRM 16
`define MDMA_CTL_MOCK 17
`define MDMA_CTL_KEYOK 18
`define MDMA_CTL_HCLR 19
// function codes and run interval limit
`define MDMA_FC_MAINT 8'h54
`define MDMA_FC_LINE 8'h48
`define MDMA_RUN_MAX 16'h270F
// timing
`define MDMA_CLK_HZ 125000000
`define MDMA_HOUR_S 3600
`define MDMA_UNIT_H 10
`define MDMA_HOLD_S 5
`endif

// ### rtl/mdma_pkg.sv
// types for the maintenance-due and mock alarm block
package mdma_pkg;
    typedef enum logic [1:0] {
        MDMA_IDLE,
        MDMA_RAISE,
        MDMA_DONE
    } mdma_mock_t;
endpackage : mdma_pkg

// ### rtl/mdma_top.sv
// maintenance-due timer and mock alarm with wishbone registers
//
// Contract
// [RQ1] run-time interval 1..9999 tens of hours, zero disables
// [RQ2] run time reaching interval asserts maintenance due
// [RQ3] startup tally reaching preset asserts maintenance due
// [RQ4] startup preset 16 bits, zero disables
// [RQ5] terminal drives flag only for code 84
// [RQ6] new interval plus confirm clears, restarts run
// [RQ7] new preset plus confirm clears, restarts count
// [RQ8] only first motor counts are compared
// [RQ9] mock request shows error, asserts alarm
// [RQ10] mock request returns to zero after raising
// [RQ11] mock change needs two-key combination
// [RQ12] mock alarm recorded in history like real
// [RQ13] history clear erases, then self-reverts
// [RQ14] two keys held five seconds raise mock
// [RQ15] tally counts startups, zero write restarts
// [RQ16] run time writable, zero clears it
// [RQ17] line-power input code 72 also accumulates
// [RQ18] flag holds until preset rewritten and confirmed
//
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/1ns
`include "mdma_params.svh"
module mdma_top
    import mdma_pkg::*;
#(
    parameter longint unsigned UNIT_CYC = longint'(`MDMA_CLK_HZ) * `MDMA_HOUR_S * `MDMA_UNIT_H,
    parameter int unsigned HOLD_CYC = `MDMA_CLK_HZ * `MDMA_HOLD_S,
    parameter int unsigned HIST_DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic motor1_run_i,
    input wire logic motor1_start_i,
    input wire logic line_power_run_input,
    input wire logic real_alarm_i,
    input wire logic [7:0] real_code_i,
    input wire logic keys_held_i,
    output logic maintenance_due_out,
    output logic do_terminal_o,
    output logic alarm_o,
    output logic err_display_o
);
    localparam logic [7:0] MOCK_CODE = 8'hEE;
    // ==========================================================
    // pin synchronisers
    logic [2:0] line_s_q;
    logic [2:0] key_s_q;
    logic line_q;
    logic key_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_s_q <= 3'h0;
            key_s_q <= 3'h0;
            line_q <= 1'b0;
            key_q <= 1'b0;
        end else begin
            line_s_q <= {line_s_q[1:0], line_power_run_input};
            key_s_q <= {key_s_q[1:0], keys_held_i};
            if (line_s_q[1] == line_s_q[2]) line_q <= line_s_q[2];
            if (key_s_q[1] == key_s_q[2]) key_q <= key_s_q[2];
        end
    end
    // ==========================================================
    // wishbone slave
    logic wr, rd_ok;
    logic ack_q;
    logic [31:0] ctrl_q;
    logic [15:0] run_set_q, st_set_q, run_cnt_q, st_cnt_q;
    logic run_due_q, st_due_q, hclr_q;
    logic [31:0] rdat;
    mdma_mock_t mock_q;
    logic [7:0] hist_q [HIST_DEPTH];
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q & wb_sel_i[0];
    assign wb_ack_o = ack_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) ack_q <= 1'b0;
        else ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
    end
    always_comb begin
        rdat = 32'h0;
        if (wb_adr_i == `MDMA_ADR_CTRL) rdat = ctrl_q;
        else if (wb_adr_i == `MDMA_ADR_RUNSET) rdat = {16'h0, run_set_q};
        else if (wb_adr_i == `MDMA_ADR_STSET) rdat = {16'h0, st_set_q};
        else if (wb_adr_i == `MDMA_ADR_RUNCNT) rdat = {16'h0, run_cnt_q};
        else if (wb_adr_i == `MDMA_ADR_STCNT) rdat = {16'h0, st_cnt_q};
        else if (wb_adr_i == `MDMA_ADR_STAT)
            rdat = {28'h0, hclr_q, alarm_o, st_due_q, run_due_q};
        else if (wb_adr_i == `MDMA_ADR_HIST)
            rdat = {hist_q[3], hist_q[2], hist_q[1], hist_q[0]};
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) wb_dat_o <= 32'h0;
        else if (wb_cyc_i & wb_stb_i & ~ack_q) wb_dat_o <= rdat;
    end
    // ==========================================================
    // control register: confirm, mock and clear bits self-clear
    logic wr_ctrl, confirm;
    logic mock_req, hist_clr_req;
    assign wr_ctrl = wr & (wb_adr_i == `MDMA_ADR_CTRL);
    assign confirm = wr_ctrl & wb_dat_i[`MDMA_CTL_CONFIRM];
    // mock bit accepted only with the key combination flag
    assign mock_req = wr_ctrl & wb_dat_i[`MDMA_CTL_MOCK] & wb_dat_i[`MDMA_CTL_KEYOK]; // RQ11
    assign hist_clr_req = wr_ctrl & wb_dat_i[`MDMA_CTL_HCLR] & wb_dat_i[`MDMA_CTL_KEYOK];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= 32'h0;
        end else begin
            if (wr_ctrl) ctrl_q[15:0] <= wb_dat_i[15:0];
            ctrl_q[`MDMA_CTL_CONFIRM] <= 1'b0;
            if (mock_req) ctrl_q[`MDMA_CTL_MOCK] <= 1'b1;
            else if (mock_q == MDMA_DONE) ctrl_q[`MDMA_CTL_MOCK] <= 1'b0; // RQ10
            ctrl_q[`MDMA_CTL_HCLR] <= hclr_q;
        end
    end
    // ==========================================================
    // presets, pending rewrite marks: only a rewrite after the event counts
    logic run_new_q, st_new_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_set_q <= 16'h0;
            st_set_q <= 16'h0;
            run_new_q <= 1'b0;
            st_new_q <= 1'b0;
        end else begin
            if (wr & (wb_adr_i == `MDMA_ADR_RUNSET) & wb_sel_i[1]) begin
                run_set_q <= (wb_dat_i[15:0] > `MDMA_RUN_MAX) ? `MDMA_RUN_MAX
                             : wb_dat_i[15:0]; // RQ1
                run_new_q <= run_due_q; // RQ6
            end else if (confirm) run_new_q <= 1'b0;
            if (wr & (wb_adr_i == `MDMA_ADR_STSET) & wb_sel_i[1]) begin
                st_set_q <= wb_dat_i[15:0]; // RQ4
                st_new_q <= st_due_q; // RQ7
            end else if (confirm) st_new_q <= 1'b0;
        end
    end
    // ==========================================================
    // first-motor run time and startup tally
    // ten hours of cycles does not fit in 32 bits
    logic [63:0] unit_q;
    logic run_restart, st_restart, start_q;
    assign run_restart = confirm & run_new_q & run_due_q; // RQ6
    assign st_restart = confirm & st_new_q & st_due_q; // RQ7
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unit_q <= 64'h0;
            run_cnt_q <= 16'h0;
            st_cnt_q <= 16'h0;
            start_q <= 1'b0;
        end else begin
            start_q <= motor1_start_i;
            if (wr & (wb_adr_i == `MDMA_ADR_RUNCNT) & wb_sel_i[1]) begin
                run_cnt_q <= wb_dat_i[15:0]; // RQ16
                unit_q <= 64'h0;
            end else if (run_restart) begin
                run_cnt_q <= 16'h0;
                unit_q <= 64'h0;
            end else if (motor1_run_i | (line_q & (ctrl_q[15:8] == `MDMA_FC_LINE))) begin // RQ17
                if (unit_q == UNIT_CYC - 64'h1) begin
                    unit_q <= 64'h0;
                    if (run_cnt_q != 16'hFFFF) run_cnt_q <= run_cnt_q + 16'h1; // RQ8
                end else unit_q <= unit_q + 64'h1;
            end
            if (wr & (wb_adr_i == `MDMA_ADR_STCNT) & wb_sel_i[1]) st_cnt_q <= wb_dat_i[15:0];
            else if (st_restart) st_cnt_q <= 16'h0;
            else if (motor1_start_i & ~start_q & (st_cnt_q != 16'hFFFF))
                st_cnt_q <= st_cnt_q + 16'h1; // RQ15
        end
    end
    // ==========================================================
    // maintenance-due flags, held until rewrite and confirm
    logic run_hit, st_hit;
    assign run_hit = (run_set_q != 16'h0) & (run_cnt_q >= run_set_q); // RQ2
    assign st_hit = (st_set_q != 16'h0) & (st_cnt_q >= st_set_q); // RQ3
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_due_q <= 1'b0;
            st_due_q <= 1'b0;
        end else begin
            if (run_restart) run_due_q <= 1'b0; // RQ18
            else if (run_hit) run_due_q <= 1'b1;
            if (st_restart) st_due_q <= 1'b0;
            else if (st_hit) st_due_q <= 1'b1;
        end
    end
    assign maintenance_due_out = run_due_q | st_due_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) do_terminal_o <= 1'b0;
        else do_terminal_o <= maintenance_due_out & (ctrl_q[7:0] == `MDMA_FC_MAINT); // RQ5
    end
    // ==========================================================
    // mock alarm sequencer and key hold timer
    logic [31:0] hold_q;
    logic hold_hit;
    assign hold_hit = key_q & (hold_q == HOLD_CYC - 1);
    always_ff @(posedge clk_i) begin
        if (rst_i) hold_q <= 32'h0;
        else if (!key_q) hold_q <= 32'h0;
        else if (hold_q != HOLD_CYC) hold_q <= hold_q + 32'h1; // RQ14
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) mock_q <= MDMA_IDLE;
        else begin
            case (mock_q)
                MDMA_IDLE: if (ctrl_q[`MDMA_CTL_MOCK] | hold_hit) mock_q <= MDMA_RAISE;
                MDMA_RAISE: mock_q <= MDMA_DONE;
                MDMA_DONE: mock_q <= MDMA_IDLE;
                default: mock_q <= MDMA_IDLE;
            endcase
        end
    end
    // alarm latched until reset; real alarms pass through
    logic mock_alarm_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) mock_alarm_q <= 1'b0;
        else if (mock_q == MDMA_RAISE) mock_alarm_q <= 1'b1; // RQ9
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_o <= 1'b0;
            err_display_o <= 1'b0;
        end else begin
            alarm_o <= mock_alarm_q | real_alarm_i;
            err_display_o <= mock_alarm_q;
        end
    end
    // ==========================================================
    // alarm history shift register
    logic rec, real_q;
    logic [7:0] rec_code;
    assign rec = (mock_q == MDMA_RAISE) | (real_alarm_i & ~real_q);
    assign rec_code = (mock_q == MDMA_RAISE) ? MOCK_CODE : real_code_i; // RQ12
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            real_q <= 1'b0;
            hclr_q <= 1'b0;
        end else begin
            real_q <= real_alarm_i;
            hclr_q <= hist_clr_req; // RQ13
        end
    end
    for (genvar i = 0; i < HIST_DEPTH; i++) begin : g_hist
        always_ff @(posedge clk_i) begin
            if (rst_i | hclr_q) hist_q[i] <= 8'h0; // RQ13
            else if (rec) hist_q[i] <= (i == 0) ? rec_code : hist_q[(i == 0) ? 0 : i - 1];
        end
    end
    // ==========================================================
    // assertions
    property p_run_due;
        @(posedge clk_i) disable iff (rst_i) run_hit & ~run_restart |=> run_due_q;
    endproperty
    a_run_due: assert property (p_run_due) else $error("run due not set"); // RQ2
    property p_st_due;
        @(posedge clk_i) disable iff (rst_i) st_hit & ~st_restart |=> st_due_q;
    endproperty
    a_st_due: assert property (p_st_due) else $error("start due not set"); // RQ3
    property p_zero_off;
        @(posedge clk_i) disable iff (rst_i)
            (run_set_q == 16'h0) & ~run_due_q |=> ~run_due_q;
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("zero interval fired"); // RQ1
    property p_st_zero;
        @(posedge clk_i) disable iff (rst_i) (st_set_q == 16'h0) & ~st_due_q |=> ~st_due_q;
    endproperty
    a_st_zero: assert property (p_st_zero) else $error("zero preset fired"); // RQ4
    property p_term;
        @(posedge clk_i) disable iff (rst_i)
            do_terminal_o |-> $past(ctrl_q[7:0]) == `MDMA_FC_MAINT;
    endproperty
    a_term: assert property (p_term) else $error("terminal without code"); // RQ5
    property p_hold;
        @(posedge clk_i) disable iff (rst_i) run_due_q & ~run_restart |=> run_due_q;
    endproperty
    a_hold: assert property (p_hold) else $error("due dropped early"); // RQ18
    property p_restart;
        @(posedge clk_i) disable iff (rst_i) run_restart |=> run_cnt_q == 16'h0;
    endproperty
    a_restart: assert property (p_restart) else $error("run not restarted"); // RQ6
    property p_mock;
        @(posedge clk_i) disable iff (rst_i) mock_q == MDMA_RAISE |=> ##1 alarm_o & err_display_o;
    endproperty
    a_mock: assert property (p_mock) else $error("mock alarm missing"); // RQ9
    property p_revert;
        @(posedge clk_i) disable iff (rst_i)
            ctrl_q[`MDMA_CTL_MOCK] & ~mock_req |-> ##[1:4] ~ctrl_q[`MDMA_CTL_MOCK];
    endproperty
    a_revert: assert property (p_revert) else $error("mock bit stuck"); // RQ10
    property p_hist;
        @(posedge clk_i) disable iff (rst_i) hclr_q |=> hist_q[0] == 8'h0;
    endproperty
    a_hist: assert property (p_hist) else $error("history not cleared"); // RQ13
    c_run: cover property (@(posedge clk_i) disable iff (rst_i) $rose(run_due_q));
    c_st: cover property (@(posedge clk_i) disable iff (rst_i) $rose(st_due_q));
    c_mock: cover property (@(posedge clk_i) disable iff (rst_i) $rose(mock_alarm_q));
    c_keys: cover property (@(posedge clk_i) disable iff (rst_i) hold_hit);
endmodule : mdma_top

// ### tb/mdma_keypad_model.sv
// drive-side model: motor status, start edges, key pair and real alarm source
`timescale 1ns/1ns
module mdma_keypad_model (
    input wire logic clk_i,
    output logic motor1_run_o,
    output logic motor1_start_o,
    output logic line_run_o,
    output logic real_alarm_o,
    output logic [7:0] real_code_o,
    output logic keys_held_o
);
    task automatic idle();
        motor1_run_o <= 1'b0;
        motor1_start_o <= 1'b0;
        line_run_o <= 1'b0;
        real_alarm_o <= 1'b0;
        real_code_o <= 8'h00;
        keys_held_o <= 1'b0;
    endtask : idle
    // =====================================
    // level and pulse tasks, all changed right after a rising edge
    task automatic set_run(input logic v);
        motor1_run_o <= v;
    endtask : set_run
    task automatic set_line(input logic v);
        line_run_o <= v;
    endtask : set_line
    task automatic start_pulse();
        motor1_start_o <= 1'b1;
        repeat (2) @(posedge clk_i);
        motor1_start_o <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : start_pulse
    task automatic hold_keys(input int n);
        keys_held_o <= 1'b1;
        repeat (n) @(posedge clk_i);
        keys_held_o <= 1'b0;
    endtask : hold_keys
    task automatic raise_real(input logic [7:0] code);
        real_code_o <= code;
        real_alarm_o <= 1'b1;
        repeat (2) @(posedge clk_i);
        real_alarm_o <= 1'b0;
        real_code_o <= ~code;
    endtask : raise_real
endmodule : mdma_keypad_model

// ### tb/maintenance_due_and_mock_alarm_tb.sv
// self-checking bench for the maintenance-due timer and mock alarm block
`timescale 1ns/1ns
module maintenance_due_and_mock_alarm_tb;
    logic clk_i = 1'b0;
    logic rst_i;
    logic cyc, stb, we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, run, start, line, ralarm, keys, due, dterm, alarm, errd;
    logic [7:0] rcode;
    int n_errors = 0;
    int comparisons = 0;
    initial forever #4 clk_i = ~clk_i;
    mdma_top #(.UNIT_CYC(20), .HOLD_CYC(10), .HIST_DEPTH(4)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .motor1_run_i(run), .motor1_start_i(start),
        .line_power_run_input(line), .real_alarm_i(ralarm), .real_code_i(rcode),
        .keys_held_i(keys), .maintenance_due_out(due), .do_terminal_o(dterm),
        .alarm_o(alarm), .err_display_o(errd));
    mdma_keypad_model pm (
        .clk_i(clk_i), .motor1_run_o(run), .motor1_start_o(start), .line_run_o(line),
        .real_alarm_o(ralarm), .real_code_o(rcode), .keys_held_o(keys));
    // =====================================
    // bus, compare and closing tasks
    task automatic test_done();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; dat <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 50) begin
            n_errors++;
            $display("mismatch at %0t: no ack", $time);
        end
        q = wb_dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk_i);
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, s, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        logic [31:0] q;
        xfer(1'b0, a, 4'hF, 32'h0, q);
        comparisons++;
        if ((q & m) !== (exp & m)) begin
            n_errors++;
            $display("mismatch at %0t: reg %h got %h want %h", $time, a, q, exp);
        end
    endtask : rd
    task automatic pin(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: pin got %b want %b", $time, got, exp);
        end
    endtask : pin
    task automatic do_reset();
        rst_i <= 1'b1;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        adr <= 8'h00;
        sel <= 4'h0;
        dat <= 32'h0;
        pm.idle();
        tick(8);
        rst_i <= 1'b0;
        tick(1);
    endtask : do_reset
    initial begin
        tick(20000);
        n_errors++;
        test_done();
    end
    // =====================================
    // main sequence
    initial begin
        do_reset();
        rd(8'h0C, 32'h0, 32'hFFFFFFFF); rd(8'h10, 32'h0, 32'hFFFFFFFF);
        rd(8'h14, 32'h0, 32'hFFFFFFFF); rd(8'h1C, 32'h0, 32'hFFFFFFFF);
        wr(8'h04, 4'h3, 32'hFFFF); rd(8'h04, 32'h270F, 32'hFFFFFFFF);
        wr(8'h04, 4'h3, 32'h0);
        wr(8'h08, 4'h3, 32'h3); rd(8'h08, 32'h3, 32'hFFFFFFFF);
        pm.start_pulse(); pm.start_pulse();
        rd(8'h10, 32'h2, 32'hFFFFFFFF); pin(due, 1'b0);
        pm.start_pulse(); tick(1);
        pin(due, 1'b1); rd(8'h14, 32'h2, 32'h3); pin(dterm, 1'b0);
        wr(8'h00, 4'hF, 32'h54); tick(1); pin(dterm, 1'b1);
        wr(8'h00, 4'hF, 32'h53); tick(1); pin(dterm, 1'b0);
        wr(8'h00, 4'hF, 32'h10054); tick(1); pin(due, 1'b1);
        wr(8'h08, 4'h3, 32'h5); wr(8'h00, 4'hF, 32'h10054); tick(1);
        pin(due, 1'b0); rd(8'h10, 32'h0, 32'hFFFFFFFF);
        wr(8'h10, 4'h3, 32'h4); pm.start_pulse(); tick(1); pin(due, 1'b1);
        wr(8'h10, 4'h3, 32'h0); rd(8'h10, 32'h0, 32'hFFFFFFFF); pin(due, 1'b1);
        wr(8'h08, 4'h3, 32'h0); wr(8'h00, 4'hF, 32'h10054);
        pm.start_pulse(); tick(1); pin(due, 1'b0);
        wr(8'h04, 4'h3, 32'h2); pm.set_run(1'b1); tick(30);
        rd(8'h0C, 32'h1, 32'hFFFFFFFF); pin(due, 1'b0);
        tick(12); pm.set_run(1'b0); tick(1);
        pin(due, 1'b1); rd(8'h14, 32'h1, 32'h3);
        wr(8'h04, 4'h3, 32'h9); wr(8'h00, 4'hF, 32'h10054); tick(1);
        pin(due, 1'b0); rd(8'h0C, 32'h0, 32'hFFFFFFFF);
        wr(8'h0C, 4'h3, 32'h9); tick(1); pin(due, 1'b1);
        wr(8'h0C, 4'h3, 32'h0); rd(8'h0C, 32'h0, 32'hFFFFFFFF); pin(due, 1'b1);
        wr(8'h04, 4'h3, 32'h0); wr(8'h00, 4'hF, 32'h10054); tick(1); pin(due, 1'b0);
        pm.set_line(1'b1); tick(30); pm.set_line(1'b0); rd(8'h0C, 32'h0, 32'hFFFF);
        wr(8'h00, 4'hF, 32'h4854);
        pm.set_line(1'b1); tick(30); pm.set_line(1'b0); rd(8'h0C, 32'h1, 32'hFFFF);
        wr(8'h00, 4'hF, 32'h20054); tick(10); pin(alarm, 1'b0);
        wr(8'h00, 4'hF, 32'h60054); tick(10);
        pin(alarm, 1'b1); pin(errd, 1'b1); rd(8'h00, 32'h54, 32'h200FF);
        rd(8'h18, 32'hEE, 32'hFF);
        wr(8'h00, 4'hF, 32'hC0054); tick(5);
        rd(8'h18, 32'h0, 32'hFFFFFFFF); rd(8'h00, 32'h0, 32'h80000);
        do_reset();
        pin(alarm, 1'b0); pm.raise_real(8'h21); tick(3);
        rd(8'h18, 32'h21, 32'hFF);
        pm.hold_keys(6); tick(20); pin(alarm, 1'b0);
        pm.hold_keys(20); tick(3); pin(alarm, 1'b1); pin(errd, 1'b1);
        rd(8'h18, 32'h21EE, 32'hFFFF);
        test_done();
    end
endmodule : maintenance_due_and_mock_alarm_tb
